/* File: rtl/link_status_pkg.sv */
// Purpose: constants and carriers for the link status word builder
// Assumes: one clock, registers reached over a plain strobe port
// Notes:   offsets of the local register map are fixed here
// How it works
// - bit 11 shows partner 100BASE-T4 ability.
// - bit 12 shows partner 100BASE-TX full-duplex ability.
// - bit 13 shows partner 100BASE-TX half-duplex ability.
// - bit 14 shows partner 10BASE-T full-duplex ability.
// - bit 15 shows partner 10BASE-T half-duplex ability.
// - partner bits and pause field valid only with no SerDes and negotiation done.
// - bit 16 shows pause enabled for transmit.
// - bit 17 shows pause enabled for receive.
// - bits 18-19 carry the partner pause ability code.
// - bit 20 shows SerDes path in use.
// - bit 21 shows vendor link settings valid.
// - all mandatory fields are built, none left out.
// - other-indications bit 0 shows host driver running.
// - without driver status support the bit reads zero.
// - a failed PHY access during gathering gives reason code 0x6.
package link_status_pkg;

  localparam int unsigned AW = 4;

  // register word addresses
  localparam logic [AW-1:0] ADDR_LINK_WORD  = 4'h0;
  localparam logic [AW-1:0] ADDR_OTHER_WORD = 4'h1;
  localparam logic [AW-1:0] ADDR_IRQ_STAT   = 4'h2;
  localparam logic [AW-1:0] ADDR_IRQ_MASK   = 4'h3;
  localparam logic [AW-1:0] ADDR_CTRL       = 4'h4;
  localparam logic [AW-1:0] ADDR_REASON     = 4'h5;

  // link status word and other-indications word field positions
  localparam int unsigned B_T4       = 11;
  localparam int unsigned B_FAST_FD  = 12;
  localparam int unsigned B_FAST_HD  = 13;
  localparam int unsigned B_TEN_FD   = 14;
  localparam int unsigned B_TEN_HD   = 15;
  localparam int unsigned B_TX_PAUSE = 16;
  localparam int unsigned B_RX_PAUSE = 17;
  localparam int unsigned B_PAUSE_LO = 18;
  localparam int unsigned B_SERDES   = 20;
  localparam int unsigned B_OEM_OK   = 21;
  localparam int unsigned B_DRIVER   = 0;

  // control register bits
  localparam int unsigned C_DRV_SUPPORT = 0;

  // interrupt status bits
  localparam int unsigned NIRQ       = 3;
  localparam int unsigned I_CHANGE   = 0;
  localparam int unsigned I_HW_ERR   = 1;
  localparam int unsigned I_DONE     = 2;

  localparam logic [7:0]  REASON_NONE    = 8'h00;
  localparam logic [7:0]  REASON_HW_ERR  = 8'h06;
  localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
  localparam logic [NIRQ-1:0] IRQ_ZERO   = 3'h0;

  typedef struct packed {
    logic       t4;
    logic       fast_fd;
    logic       fast_hd;
    logic       ten_fd;
    logic       ten_hd;
    logic [1:0] pause;
    logic       tx_pause;
    logic       rx_pause;
    logic       serdes;
    logic       an_enable;
    logic       an_complete;
    logic       oem_valid;
    logic       driver_up;
  } phy_state_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic          wr;
    logic          rd;
  } bus_req_t;

  typedef enum logic [1:0] {S_IDLE, S_GATHER, S_DONE} gather_state_t;

endpackage

/* File: rtl/link_status_word_builder.sv */
// Purpose: build the upper link status bits and the other-indications word
// Assumes: PHY state inputs come from other clock domains and are synchronised
// Notes:   a gather without access error captures both words; a PHY access error sets reason 0x6
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module link_status_word_builder (
  input  wire logic                          MCLK_I,
  input  wire logic                          RSTN_I,
  input  wire link_status_pkg::phy_state_t   PHY_STATE_I,
  input  wire logic                          GATHER_I,
  input  wire logic                          PHY_ACCESS_DONE_I,
  input  wire logic                          PHY_ACCESS_ERR_I,
  input  wire logic [link_status_pkg::AW-1:0] ADDR_I,
  input  wire logic [31:0]                   WDATA_I,
  input  wire logic                          WR_I,
  input  wire logic                          RD_I,
  output logic [31:0]                        RDATA_O,
  output logic [31:0]                        LINK_WORD_O,
  output logic [31:0]                        OTHER_WORD_O,
  output logic [7:0]                         REASON_O,
  output logic                               DONE_O,
  output logic                               IRQ_O
);

  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  logic                        rst_s1_ff;
  logic                        rst_n_ff;
  link_status_pkg::phy_state_t ph_s1_ff;
  link_status_pkg::phy_state_t ph_s2_ff;

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ph_s1_ff <= '0;
      ph_s2_ff <= '0;
    end else begin
      ph_s1_ff <= PHY_STATE_I;
      ph_s2_ff <= ph_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // word assembly
  // ----------------------------------------------------------------
  logic        drv_support_ff;
  logic        nxt_drv_support;
  logic        partner_valid;
  logic [31:0] link_word;
  logic [31:0] other_word;

  always_comb begin
    partner_valid = !ph_s2_ff.serdes && ph_s2_ff.an_enable && ph_s2_ff.an_complete;
    link_word  = link_status_pkg::WORD_ZERO;
    other_word = link_status_pkg::WORD_ZERO;
    if (partner_valid) begin
      link_word[link_status_pkg::B_T4]      = ph_s2_ff.t4;
      link_word[link_status_pkg::B_FAST_FD] = ph_s2_ff.fast_fd;
      link_word[link_status_pkg::B_FAST_HD] = ph_s2_ff.fast_hd;
      link_word[link_status_pkg::B_TEN_FD]  = ph_s2_ff.ten_fd;
      link_word[link_status_pkg::B_TEN_HD]  = ph_s2_ff.ten_hd;
      link_word[link_status_pkg::B_PAUSE_LO +: 2] = ph_s2_ff.pause;
    end
    link_word[link_status_pkg::B_TX_PAUSE] = ph_s2_ff.tx_pause;
    link_word[link_status_pkg::B_RX_PAUSE] = ph_s2_ff.rx_pause;
    link_word[link_status_pkg::B_SERDES]   = ph_s2_ff.serdes;
    link_word[link_status_pkg::B_OEM_OK]   = ph_s2_ff.oem_valid;
    other_word[link_status_pkg::B_DRIVER]  = drv_support_ff && ph_s2_ff.driver_up;
  end

  // ----------------------------------------------------------------
  // gather sequence
  // ----------------------------------------------------------------
  link_status_pkg::gather_state_t st_ff;
  link_status_pkg::gather_state_t nxt_st;
  logic [31:0] link_ff;
  logic [31:0] nxt_link;
  logic [31:0] other_ff;
  logic [31:0] nxt_other;
  logic [7:0]  reason_ff;
  logic [7:0]  nxt_reason;
  logic        done_ff;
  logic        nxt_done;
  logic        err_ev;

  always_comb begin
    nxt_st     = st_ff;
    nxt_link   = link_ff;
    nxt_other  = other_ff;
    nxt_reason = reason_ff;
    nxt_done   = 1'b0;
    err_ev     = 1'b0;
    unique case (st_ff)
      link_status_pkg::S_IDLE: begin
        if (GATHER_I) begin
          nxt_st     = link_status_pkg::S_GATHER;
          nxt_reason = link_status_pkg::REASON_NONE;
        end
      end
      link_status_pkg::S_GATHER: begin
        if (PHY_ACCESS_ERR_I) begin
          nxt_reason = link_status_pkg::REASON_HW_ERR;
          err_ev     = 1'b1;
          nxt_st     = link_status_pkg::S_DONE;
        end else if (PHY_ACCESS_DONE_I) begin
          nxt_link  = link_word;
          nxt_other = other_word;
          nxt_st    = link_status_pkg::S_DONE;
        end
      end
      link_status_pkg::S_DONE: begin
        nxt_done = 1'b1;
        nxt_st   = link_status_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff     <= link_status_pkg::S_IDLE;
      link_ff   <= link_status_pkg::WORD_ZERO;
      other_ff  <= link_status_pkg::WORD_ZERO;
      reason_ff <= link_status_pkg::REASON_NONE;
      done_ff   <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      link_ff   <= nxt_link;
      other_ff  <= nxt_other;
      reason_ff <= nxt_reason;
      done_ff   <= nxt_done;
    end
  end

  // ----------------------------------------------------------------
  // interrupts, control and register port
  // ----------------------------------------------------------------
  logic [link_status_pkg::NIRQ-1:0] stat_ff;
  logic [link_status_pkg::NIRQ-1:0] nxt_stat;
  logic [link_status_pkg::NIRQ-1:0] mask_ff;
  logic [link_status_pkg::NIRQ-1:0] nxt_mask;
  logic [link_status_pkg::NIRQ-1:0] ev;
  logic [31:0] prev_word_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        irq_ff;
  logic        nxt_irq;

  always_comb begin
    ev = link_status_pkg::IRQ_ZERO;
    ev[link_status_pkg::I_CHANGE] = (link_word != prev_word_ff);
    ev[link_status_pkg::I_HW_ERR] = err_ev;
    ev[link_status_pkg::I_DONE]   = nxt_done;
    nxt_mask        = mask_ff;
    nxt_drv_support = drv_support_ff;
    nxt_stat        = stat_ff;
    if (WR_I && ADDR_I == link_status_pkg::ADDR_IRQ_STAT) begin
      nxt_stat = stat_ff & ~WDATA_I[link_status_pkg::NIRQ-1:0];
    end
    nxt_stat = nxt_stat | ev; // set wins over clear
    if (WR_I && ADDR_I == link_status_pkg::ADDR_IRQ_MASK) begin
      nxt_mask = WDATA_I[link_status_pkg::NIRQ-1:0];
    end
    if (WR_I && ADDR_I == link_status_pkg::ADDR_CTRL) begin
      nxt_drv_support = WDATA_I[link_status_pkg::C_DRV_SUPPORT];
    end
    nxt_irq   = |(nxt_stat & nxt_mask);
    nxt_rdata = link_status_pkg::WORD_ZERO;
    if (RD_I) begin
      unique case (ADDR_I)
        link_status_pkg::ADDR_LINK_WORD:  nxt_rdata = link_ff;
        link_status_pkg::ADDR_OTHER_WORD: nxt_rdata = other_ff;
        link_status_pkg::ADDR_IRQ_STAT:   nxt_rdata[link_status_pkg::NIRQ-1:0] = stat_ff;
        link_status_pkg::ADDR_IRQ_MASK:   nxt_rdata[link_status_pkg::NIRQ-1:0] = mask_ff;
        link_status_pkg::ADDR_CTRL:
          nxt_rdata[link_status_pkg::C_DRV_SUPPORT] = drv_support_ff;
        link_status_pkg::ADDR_REASON:     nxt_rdata[7:0] = reason_ff;
        default:                          nxt_rdata = link_status_pkg::WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      stat_ff        <= link_status_pkg::IRQ_ZERO;
      mask_ff        <= link_status_pkg::IRQ_ZERO;
      drv_support_ff <= 1'b0;
      prev_word_ff   <= link_status_pkg::WORD_ZERO;
      rdata_ff       <= link_status_pkg::WORD_ZERO;
      irq_ff         <= 1'b0;
    end else begin
      stat_ff        <= nxt_stat;
      mask_ff        <= nxt_mask;
      drv_support_ff <= nxt_drv_support;
      prev_word_ff   <= link_word;
      rdata_ff       <= nxt_rdata;
      irq_ff         <= nxt_irq;
    end
  end

  assign RDATA_O      = rdata_ff;
  assign LINK_WORD_O  = link_ff;
  assign OTHER_WORD_O = other_ff;
  assign REASON_O     = reason_ff;
  assign DONE_O       = done_ff;
  assign IRQ_O        = irq_ff;

endmodule

/* File: verif/link_status_word_builder_asserts.sv */
// Purpose: port checks of the link status word builder
// Assumes: gathers start only in idle
// Notes:   bound from the bench top
`timescale 1ns/10ps
module link_status_word_builder_asserts (
  input wire logic                            MCLK_I,
  input wire logic                            RSTN_I,
  input wire logic                            GATHER_I,
  input wire logic                            PHY_ACCESS_DONE_I,
  input wire logic                            PHY_ACCESS_ERR_I,
  input wire logic [link_status_pkg::AW-1:0]  ADDR_I,
  input wire logic                            RD_I,
  input wire logic [31:0]                     RDATA_O,
  input wire logic [31:0]                     LINK_WORD_O,
  input wire logic [31:0]                     OTHER_WORD_O,
  input wire logic [7:0]                      REASON_O,
  input wire logic                            DONE_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  // ----------------------------------------
  // gather sequences
  // ----------------------------------------
  sequence s_ok;
    GATHER_I ##1 (PHY_ACCESS_DONE_I && !PHY_ACCESS_ERR_I);
  endsequence
  sequence s_err;
    GATHER_I ##1 PHY_ACCESS_ERR_I;
  endsequence
  chk_ok_reason: assert property (s_ok |=> REASON_O == link_status_pkg::REASON_NONE ##1 DONE_O)
    else $error("reason or done wrong after good access");
  chk_err_reason: assert property (s_err |=> REASON_O == link_status_pkg::REASON_HW_ERR ##1 DONE_O)
    else $error("reason or done wrong after failed access");
  chk_done_single: assert property (DONE_O |=> !DONE_O)
    else $error("done longer than one cycle");
  chk_link_resv: assert property (LINK_WORD_O[31:22] == 10'h000)
    else $error("link word reserved bits set");
  chk_other_resv: assert property (OTHER_WORD_O[31:1] == 31'h0)
    else $error("other word reserved bits set");
  chk_serdes_gate: assert property (LINK_WORD_O[20] |-> (LINK_WORD_O[19:11] & 9'h19F) == 9'h0)
    else $error("partner bits shown with serdes");
  chk_words_hold: assert property (!(PHY_ACCESS_DONE_I || PHY_ACCESS_ERR_I) |=>
    ($stable(LINK_WORD_O) && $stable(OTHER_WORD_O)))
    else $error("words moved without access end");
  chk_rd_idle: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data outside read slot");
  chk_rd_link: assert property (RD_I && ADDR_I == link_status_pkg::ADDR_LINK_WORD
    |=> RDATA_O == $past(LINK_WORD_O))
    else $error("link word read back wrong");
endmodule

/* File: verif/link_status_word_builder_tb_top.sv */
// Purpose: self-checking bench of the link status word builder
// Assumes: one clock at 125 MHz
// Notes:   rows sweep link states, hand tests cover errors and irq
`timescale 1ns/10ps
module link_status_word_builder_tb_top;
  logic                        clk, rst_n, gather, phy_done, phy_err, wr, rd, fail, done, irq;
  logic [1:0]                  dly;
  logic [3:0]                  addr;
  logic [31:0]                 wdata, rdata, link_w, other_w, d;
  logic [7:0]                  reason;
  link_status_pkg::phy_state_t st;
  int                          n_fail, checks;
  typedef struct packed {
    logic [13:0] st;
    logic [31:0] link;
    logic        drv;
  } row_t;
  // link state in, captured link word and driver bit expected out
  row_t                        rows [7] = '{'{14'h3FEF, 32'h002F_F800, 1'b0},
    '{14'h3FFF, 32'h0033_0000, 1'b1}, '{14'h3FE7, 32'h0023_0000, 1'b0},
    '{14'h3FEB, 32'h0023_0000, 1'b1}, '{14'h20CC, 32'h0005_0800, 1'b0},
    '{14'h032E, 32'h002A_8000, 1'b0}, '{14'h0000, 32'h0000_0000, 1'b0}};
  link_status_word_builder u_link_status_word_builder (.MCLK_I(clk), .RSTN_I(rst_n),
    .PHY_STATE_I(st), .GATHER_I(gather), .PHY_ACCESS_DONE_I(phy_done),
    .PHY_ACCESS_ERR_I(phy_err), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .LINK_WORD_O(link_w), .OTHER_WORD_O(other_w), .REASON_O(reason),
    .DONE_O(done), .IRQ_O(irq));
  phy_access_model u_phy_access_model (.clk_i(clk), .gather_i(gather), .fail_i(fail),
    .delay_i(dly), .done_o(phy_done), .err_o(phy_err));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk); addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic run_gather(input logic f, input logic [1:0] dl);
    @(posedge clk); gather <= 1'b1; fail <= f; dly <= dl;
    @(posedge clk); gather <= 1'b0;
    for (int i = 0; i < 20 && done !== 1'b1; i++) begin @(posedge clk); #1; end
    if (done !== 1'b1) begin n_fail++; tally_and_finish; end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0; gather = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 32'h0;
    st = '0; fail = 1'b0; dly = 2'h0; n_fail = 0; checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1 cmp(32'h0, link_w | other_w | {31'h0, irq});
    foreach (rows[i]) begin
      wr_reg(link_status_pkg::ADDR_CTRL, {31'h0, i[0]});
      @(posedge clk); st <= link_status_pkg::phy_state_t'(rows[i].st);
      repeat (4) @(posedge clk);
      run_gather(1'b0, {i[1], 1'b0});
      cmp(rows[i].link, link_w);
      cmp({31'h0, rows[i].drv}, other_w);
      rd_reg(link_status_pkg::ADDR_LINK_WORD, d); cmp(rows[i].link, d);
      rd_reg(link_status_pkg::ADDR_OTHER_WORD, d); cmp({31'h0, rows[i].drv}, d);
    end
    wr_reg(link_status_pkg::ADDR_IRQ_STAT, 32'h7);
    wr_reg(link_status_pkg::ADDR_IRQ_MASK, 32'h2);
    run_gather(1'b1, 2'h0);
    cmp(32'h6, {24'h0, reason});
    @(posedge clk); #1 cmp(32'h1, {31'h0, irq});
    rd_reg(link_status_pkg::ADDR_IRQ_STAT, d); cmp(32'h6, d);
    wr_reg(link_status_pkg::ADDR_IRQ_STAT, 32'h2);
    @(posedge clk); #1 cmp(32'h0, {31'h0, irq});
    wr_reg(link_status_pkg::ADDR_REASON, 32'h0);
    rd_reg(link_status_pkg::ADDR_REASON, d); cmp(32'h6, d);
    rd_reg(4'hF, d); cmp(32'h0, d);
    rd_reg(link_status_pkg::ADDR_IRQ_MASK, d); cmp(32'h2, d);
    wr_reg(link_status_pkg::ADDR_CTRL, 32'h1);
    rd_reg(link_status_pkg::ADDR_CTRL, d); cmp(32'h1, d);
    run_gather(1'b0, 2'h2);
    cmp(32'h0, {24'h0, reason});
    // a live link change sets the change bit beside the done bit
    @(posedge clk); st <= link_status_pkg::phy_state_t'(rows[0].st);
    repeat (4) @(posedge clk);
    rd_reg(link_status_pkg::ADDR_IRQ_STAT, d); cmp(32'h5, d);
    tally_and_finish;
  end
endmodule
bind link_status_word_builder link_status_word_builder_asserts u_chk (.MCLK_I(MCLK_I),
  .RSTN_I(RSTN_I), .GATHER_I(GATHER_I), .PHY_ACCESS_DONE_I(PHY_ACCESS_DONE_I),
  .PHY_ACCESS_ERR_I(PHY_ACCESS_ERR_I), .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .LINK_WORD_O(LINK_WORD_O), .OTHER_WORD_O(OTHER_WORD_O), .REASON_O(REASON_O),
  .DONE_O(DONE_O));

/* File: verif/phy_access_model.sv */
// Purpose: PHY access engine answering gathers
// Assumes: delay 0 answers next cycle
// Notes:   fail_i picks the error pulse
`timescale 1ns/10ps
module phy_access_model (
  input  wire logic       clk_i,
  input  wire logic       gather_i,
  input  wire logic       fail_i,
  input  wire logic [1:0] delay_i,
  output logic            done_o,
  output logic            err_o
);
  logic [1:0] cnt_ff = 2'h0;
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    err_o  <= 1'b0;
    if ((gather_i && delay_i == 2'h0) || cnt_ff == 2'h1) begin
      done_o <= !fail_i;
      err_o  <= fail_i;
    end
    cnt_ff <= gather_i ? delay_i : (cnt_ff != 2'h0 ? cnt_ff - 2'h1 : 2'h0);
  end
endmodule
